//--- shared/c3d_pkg.sv
// Package for the channel three clock divider: offsets, fields, resets, carriers
package c3d_pkg;

	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [8:0] C3D_OFS_FIRST_LH = 9'h19e;
	localparam logic [8:0] C3D_OFS_PHASE = 9'h19f;
	localparam logic [8:0] C3D_OFS_SECOND_LH = 9'h1a0;
	localparam logic [8:0] C3D_OFS_CTRL = 9'h1a1;
	localparam logic [8:0] C3D_OFS_DCC = 9'h1a2;
	localparam logic [8:0] C3D_OFS_STATUS = 9'h1a3;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int C3D_LOW_LSB = 4;
	localparam int C3D_HIGH_LSB = 0;
	localparam int C3D_PH2_LSB = 4;
	localparam int C3D_PH1_LSB = 0;
	localparam int C3D_FLD_W = 4;
	localparam int C3D_BIT_BYP2 = 5;
	localparam int C3D_BIT_BYP1 = 4;
	localparam int C3D_BIT_NOSYNC = 3;
	localparam int C3D_BIT_FORCE = 2;
	localparam int C3D_BIT_START2 = 1;
	localparam int C3D_BIT_START1 = 0;
	localparam int C3D_BIT_DCC_OFF = 0;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] C3D_RST_FIRST_LH = 8'h00;
	localparam logic [7:0] C3D_RST_PHASE = 8'h00;
	localparam logic [7:0] C3D_RST_SECOND_LH = 8'h00;
	localparam logic [7:0] C3D_RST_CTRL = 8'h00;
	localparam logic [7:0] C3D_RST_DCC = 8'h00;

	// ****************************************
	// Stage phase and settings carrier
	// ****************************************
	typedef enum logic [1:0] {
		C3D_ST_OFF = 2'b00,
		C3D_ST_WAIT = 2'b01,
		C3D_ST_RUN = 2'b10
	} c3d_state_t;

	typedef struct packed {
		logic [3:0] low_cnt;
		logic [3:0] high_cnt;
		logic [3:0] phase;
		logic start_high;
		logic bypass;
		logic balance;
	} c3d_stage_cfg_t;

endpackage

//--- hw/c3d_stage.sv
// One sub-divider stage of the channel three clock divider
`timescale 1ns/1ns
`default_nettype none
module c3d_stage #(
	parameter int CNT_W = 4
) (
	input wire logic clk_sys, // System clock
	input wire logic rstn, // Synchronous reset, active low
	input wire c3d_pkg::c3d_stage_cfg_t cfg, // Stage settings
	input wire logic restart, // Hold in restart state
	input wire logic in_lvl, // Stage input clock level
	output logic out_lvl, // Stage output level
	output c3d_pkg::c3d_state_t state // Stage phase
);
	import c3d_pkg::*;

	// ****************************************
	// Local state
	// ****************************************
	logic in_q;
	logic rise;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] wait_q;
	logic [CNT_W-1:0] limit;
	logic [CNT_W:0] ratio;
	c3d_state_t st_q;

	if (CNT_W != C3D_FLD_W) begin : g_chk
		$error("c3d_stage: CNT_W must match the 4-bit count fields");
	end

	// Input edge seen once per input cycle
	assign rise = in_lvl & ~in_q;

	// Level length; balanced split when correction applies to even ratios
	always_comb begin
		ratio = {1'b0, cfg.low_cnt} + {1'b0, cfg.high_cnt} + 5'h02;
		limit = out_lvl ? cfg.high_cnt : cfg.low_cnt;
		if (cfg.balance && !ratio[0]) begin
			limit = ratio[CNT_W:1] - 4'h1;
		end
	end

	// Previous input level
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			in_q <= 1'b0;
		end else begin
			in_q <= in_lvl;
		end
	end

	// Counting, phase wait and output level
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_q <= C3D_ST_WAIT;
			cnt_q <= '0;
			wait_q <= '0;
			out_lvl <= 1'b0;
		end else if (cfg.bypass) begin
			st_q <= C3D_ST_OFF;
			cnt_q <= '0;
			wait_q <= '0;
			out_lvl <= in_lvl;
		end else if (restart || st_q == C3D_ST_OFF) begin
			st_q <= C3D_ST_WAIT;
			cnt_q <= '0;
			wait_q <= cfg.phase;
			out_lvl <= cfg.start_high;
		end else if (rise) begin
			case (st_q)
				C3D_ST_WAIT: begin
					if (wait_q == '0) begin
						st_q <= C3D_ST_RUN;
						cnt_q <= (limit == '0) ? '0 : 4'h1;
						out_lvl <= (limit == '0) ? ~out_lvl : out_lvl;
					end else begin
						wait_q <= wait_q - 4'h1;
					end
				end
				default: begin
					if (cnt_q >= limit) begin
						cnt_q <= '0;
						out_lvl <= ~out_lvl;
					end else begin
						cnt_q <= cnt_q + 4'h1;
					end
				end
			endcase
		end
	end

	assign state = st_q;
endmodule
`default_nettype wire

//--- hw/c3d_top.sv
// Channel three clock divider: registers, sync handling and two stages
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module c3d_top #(
	parameter int ADDR_W = 9,
	parameter int DATA_W = 8
) (
	input wire logic clk_sys, // System clock, 50 MHz
	input wire logic rstn, // Synchronous reset, active low
	input wire logic [ADDR_W-1:0] reg_addr, // Register address
	input wire logic [DATA_W-1:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
	input wire logic div_clk_in, // Channel divider input clock level
	input wire logic sync_in, // Chip-level sync, active high
	output logic chan_out // Channel clock output
);
	import c3d_pkg::*;

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (ADDR_W < 9) begin : g_chk_addr
		$error("c3d_top: ADDR_W too narrow for register map");
	end
	if (DATA_W != 8) begin : g_chk_data
		$error("c3d_top: DATA_W must be 8");
	end

	// ****************************************
	// Register storage
	// ****************************************
	logic [7:0] first_lh_q;
	logic [7:0] phase_q;
	logic [7:0] second_lh_q;
	logic [7:0] ctrl_q;
	logic [7:0] dcc_q;

	// ****************************************
	// Decoded controls
	// ****************************************
	logic byp2;
	logic byp1;
	logic nosync;
	logic force_high;
	logic start2;
	logic start1;
	logic duty_correction_disable;

	// ****************************************
	// Stage wiring
	// ****************************************
	c3d_stage_cfg_t cfg1;
	c3d_stage_cfg_t cfg2;
	logic restart;
	logic out1;
	logic out2;
	c3d_state_t st1;
	c3d_state_t st2;
	logic force_now;
	logic [7:0] status;
	logic [7:0] rd_d;

	// ****************************************
	// Register writes
	// ****************************************

	// First stage low/high counts
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			first_lh_q <= C3D_RST_FIRST_LH;
		end else if (reg_wr && reg_addr == ADDR_W'(C3D_OFS_FIRST_LH)) begin
			first_lh_q <= reg_wdata;
		end
	end

	// Phase offsets of both stages
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			phase_q <= C3D_RST_PHASE;
		end else if (reg_wr && reg_addr == ADDR_W'(C3D_OFS_PHASE)) begin
			phase_q <= reg_wdata;
		end
	end

	// Second stage low/high counts
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			second_lh_q <= C3D_RST_SECOND_LH;
		end else if (reg_wr && reg_addr == ADDR_W'(C3D_OFS_SECOND_LH)) begin
			second_lh_q <= reg_wdata;
		end
	end

	// Control bits; the two top bits stay zero
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ctrl_q <= C3D_RST_CTRL;
		end else if (reg_wr && reg_addr == ADDR_W'(C3D_OFS_CTRL)) begin
			ctrl_q <= {2'b00, reg_wdata[5:0]};
		end
	end

	// Duty correction; only bit 0 is kept
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			dcc_q <= C3D_RST_DCC;
		end else if (reg_wr && reg_addr == ADDR_W'(C3D_OFS_DCC)) begin
			dcc_q <= {7'h00, reg_wdata[0]};
		end
	end

	// ****************************************
	// Control decode
	// ****************************************

	// Single control bits
	assign byp2 = ctrl_q[C3D_BIT_BYP2];
	assign byp1 = ctrl_q[C3D_BIT_BYP1];
	assign nosync = ctrl_q[C3D_BIT_NOSYNC];
	assign force_high = ctrl_q[C3D_BIT_FORCE];
	assign start2 = ctrl_q[C3D_BIT_START2];
	assign start1 = ctrl_q[C3D_BIT_START1];
	assign duty_correction_disable = dcc_q[C3D_BIT_DCC_OFF];

	// ****************************************
	// Stage settings
	// ****************************************

	// First stage counts, offset, start level and bypass
	always_comb begin
		cfg1.low_cnt = first_lh_q[C3D_LOW_LSB +: C3D_FLD_W];
		cfg1.high_cnt = first_lh_q[C3D_HIGH_LSB +: C3D_FLD_W];
		cfg1.phase = phase_q[C3D_PH1_LSB +: C3D_FLD_W];
		cfg1.start_high = start1;
		cfg1.bypass = byp1;
		cfg1.balance = ~duty_correction_disable;
	end

	// Second stage counts, offset, start level and bypass
	always_comb begin
		cfg2.low_cnt = second_lh_q[C3D_LOW_LSB +: C3D_FLD_W];
		cfg2.high_cnt = second_lh_q[C3D_HIGH_LSB +: C3D_FLD_W];
		cfg2.phase = phase_q[C3D_PH2_LSB +: C3D_FLD_W];
		cfg2.start_high = start2;
		cfg2.bypass = byp2;
		cfg2.balance = ~duty_correction_disable;
	end

	// ****************************************
	// Sync handling
	// ****************************************

	// Sync holds both stages in restart unless ignored
	assign restart = sync_in & ~nosync;

	// Static output only while sync is ignored and asserted
	assign force_now = nosync & sync_in;

	// ****************************************
	// Divider stages
	// ****************************************

	// First stage runs on the channel input clock
	c3d_stage #(
		.CNT_W(C3D_FLD_W)
	) u_first (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.cfg(cfg1),
		.restart(restart),
		.in_lvl(div_clk_in),
		.out_lvl(out1),
		.state(st1)
	);

	// Second stage is clocked by the first stage output
	c3d_stage #(
		.CNT_W(C3D_FLD_W)
	) u_second (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.cfg(cfg2),
		.restart(restart),
		.in_lvl(out1),
		.out_lvl(out2),
		.state(st2)
	);

	// ****************************************
	// Channel output
	// ****************************************

	// Registered output, forced level overrides divided clock
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			chan_out <= 1'b0;
		end else if (force_now) begin
			chan_out <= force_high;
		end else begin
			chan_out <= out2;
		end
	end

	// ****************************************
	// Status and read-back
	// ****************************************

	// Live view of both stages and the sync path
	assign status = {
		force_now,
		restart,
		st2 == C3D_ST_RUN,
		st1 == C3D_ST_RUN,
		st2 == C3D_ST_OFF,
		st1 == C3D_ST_OFF,
		out2,
		out1
	};

	// Read data selection; unmapped reads return zero
	always_comb begin
		rd_d = 8'h00;
		if (reg_addr == ADDR_W'(C3D_OFS_FIRST_LH)) begin
			rd_d = first_lh_q;
		end else if (reg_addr == ADDR_W'(C3D_OFS_PHASE)) begin
			rd_d = phase_q;
		end else if (reg_addr == ADDR_W'(C3D_OFS_SECOND_LH)) begin
			rd_d = second_lh_q;
		end else if (reg_addr == ADDR_W'(C3D_OFS_CTRL)) begin
			rd_d = ctrl_q;
		end else if (reg_addr == ADDR_W'(C3D_OFS_DCC)) begin
			rd_d = dcc_q;
		end else if (reg_addr == ADDR_W'(C3D_OFS_STATUS)) begin
			rd_d = status;
		end
	end

	// Read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_d;
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire

//--- tb/c3d_monitor.sv
// Port checker for the channel three clock divider
`timescale 1ns/1ns
`default_nettype none
module c3d_monitor #(
	parameter int ADDR_W = 9,
	parameter int DATA_W = 8
) (
	input wire logic clk_sys, // Clock
	input wire logic rstn, // Reset
	input wire logic [ADDR_W-1:0] reg_addr, // Address
	input wire logic [DATA_W-1:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [DATA_W-1:0] reg_rdata, // Read data
	input wire logic div_clk_in, // Input clock
	input wire logic sync_in, // Sync
	input wire logic chan_out // Output
);
	import c3d_pkg::*;
	logic [7:0] lh1_q, ph_q, lh2_q, ctl_q, dcc_q;
	// ********
	// Shadow copies of the registers
	// ********
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			lh1_q <= 8'h00;
			ph_q <= 8'h00;
			lh2_q <= 8'h00;
			ctl_q <= 8'h00;
			dcc_q <= 8'h00;
		end else if (reg_wr) begin
			case (reg_addr)
				C3D_OFS_FIRST_LH: lh1_q <= reg_wdata;
				C3D_OFS_PHASE: ph_q <= reg_wdata;
				C3D_OFS_SECOND_LH: lh2_q <= reg_wdata;
				C3D_OFS_CTRL: ctl_q <= reg_wdata;
				C3D_OFS_DCC: dcc_q <= reg_wdata;
				default: ;
			endcase
		end
	end
	// ********
	// Assertions
	// ********
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property rd_p(logic [8:0] o, logic [7:0] v);
		$past(reg_rd) && $past(reg_addr) == o |-> reg_rdata == $past(v);
	endproperty
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	rd_lh1_a: assert property (rd_p(C3D_OFS_FIRST_LH, lh1_q))
		else $error("first counts read wrong");
	rd_ph_a: assert property (rd_p(C3D_OFS_PHASE, ph_q))
		else $error("phase read wrong");
	rd_lh2_a: assert property (rd_p(C3D_OFS_SECOND_LH, lh2_q))
		else $error("second counts read wrong");
	rd_ctl_a: assert property ($past(reg_rd) && $past(reg_addr) == C3D_OFS_CTRL
		|-> reg_rdata == {2'b00, $past(ctl_q[5:0])})
		else $error("control read wrong");
	rd_dcc_a: assert property ($past(reg_rd) && $past(reg_addr) == C3D_OFS_DCC
		|-> reg_rdata == {7'h00, $past(dcc_q[0])})
		else $error("duty read wrong");
	rd_void_a: assert property ($past(reg_rd) && $past(reg_addr) > 9'h1a3 |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	force_out_a: assert property ((ctl_q[3] && sync_in) [*3] |=> chan_out == $past(ctl_q[2]))
		else $error("forced level wrong");
	sync_hold_a: assert property ((!ctl_q[3] && sync_in && ctl_q[5:4] == 2'b00) [*8]
		|-> chan_out == ctl_q[1])
		else $error("second start level wrong");
	sync_first_a: assert property ((!ctl_q[3] && sync_in && ctl_q[5:4] == 2'b10) [*8]
		|-> chan_out == ctl_q[0])
		else $error("first start level wrong");
	cover property (ctl_q[3] && sync_in && chan_out);
	cover property (!ctl_q[3] && sync_in && ctl_q[1] && chan_out);
	cover property ($rose(chan_out) && ctl_q[5:4] == 2'b00);
endmodule
bind c3d_top c3d_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) c3d_monitor_inst (.clk_sys(clk_sys),
	.rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .div_clk_in(div_clk_in), .sync_in(sync_in), .chan_out(chan_out));
`default_nettype wire

//--- tb/c3d_top_bench.sv
// Testbench for the channel three clock divider
`timescale 1ns/1ns
`default_nettype none
module c3d_top_bench;
	import c3d_pkg::*;
	logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic div_clk_in = 1'b0, sync_in = 1'b0, chan_out;
	logic [8:0] reg_addr = 9'h000;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, n;
	logic [1:0] ph = 2'h0;
	int bad_count = 0, n_compared = 0;
	c3d_top c3d_top_inst (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .div_clk_in(div_clk_in),
		.sync_in(sync_in), .chan_out(chan_out));
	always #10 clk_sys = ~clk_sys;
	// Divider input clock, four system cycles a period
	always @(posedge clk_sys) begin
		ph <= ph + 2'h1;
		div_clk_in <= ph[1];
	end
	// ********
	// Tasks
	// ********
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [8:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk("read data", e, reg_rdata);
	endtask
	// Counts system cycles while the output keeps one level
	task span(input logic v, output logic [7:0] k);
		k = 8'h00;
		while (chan_out === v && k < 8'hc8) begin
			@(posedge clk_sys);
			#1;
			k++;
		end
	endtask
	task meas(input logic [7:0] hi, input logic [7:0] lo);
		repeat (100) @(posedge clk_sys);
		#1;
		span(1'b1, n);
		span(1'b0, n);
		span(1'b1, n);
		chk("high time", hi, n);
		span(1'b0, n);
		chk("low time", lo, n);
	endtask
	task hold(input logic [7:0] c, input logic e);
		wr(C3D_OFS_CTRL, c);
		sync_in <= 1'b1;
		repeat (12) @(posedge clk_sys);
		#1;
		chk("held level", {7'h00, e}, {7'h00, chan_out});
		@(posedge clk_sys);
		sync_in <= 1'b0;
	endtask
	task close_out;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ********
	// Sequence
	// ********
	initial begin
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(9'h19e + 9'(i), 8'h00);
		end
		wr(C3D_OFS_CTRL, 8'hff);
		rd(C3D_OFS_CTRL, 8'h3f);
		wr(C3D_OFS_DCC, 8'hff);
		rd(C3D_OFS_DCC, 8'h01);
		wr(C3D_OFS_PHASE, 8'ha5);
		rd(C3D_OFS_PHASE, 8'ha5);
		wr(9'h1a4, 8'h5a);
		rd(9'h1a4, 8'h00);
		wr(C3D_OFS_PHASE, 8'h00);
		wr(C3D_OFS_CTRL, 8'h10);
		wr(C3D_OFS_SECOND_LH, 8'h12);
		meas(8'd12, 8'd8);
		wr(C3D_OFS_DCC, 8'h00);
		wr(C3D_OFS_SECOND_LH, 8'h02);
		meas(8'd8, 8'd8);
		wr(C3D_OFS_DCC, 8'h01);
		wr(C3D_OFS_CTRL, 8'h00);
		wr(C3D_OFS_FIRST_LH, 8'h10);
		wr(C3D_OFS_SECOND_LH, 8'h01);
		meas(8'd24, 8'd12);
		wr(C3D_OFS_CTRL, 8'h30);
		meas(8'd2, 8'd2);
		wr(C3D_OFS_CTRL, 8'h20);
		wr(C3D_OFS_FIRST_LH, 8'h21);
		meas(8'd8, 8'd12);
		hold(8'h02, 1'b1);
		hold(8'h04, 1'b0);
		hold(8'h21, 1'b1);
		hold(8'h0c, 1'b1);
		hold(8'h08, 1'b0);
		// Status under an obeyed sync: only the restart flag is up, and writes to it are ignored
		wr(C3D_OFS_CTRL, 8'h04);
		sync_in <= 1'b1;
		repeat (4) @(posedge clk_sys);
		wr(C3D_OFS_STATUS, 8'hff);
		rd(C3D_OFS_STATUS, 8'h40);
		@(posedge clk_sys);
		sync_in <= 1'b0;
		close_out();
	end
	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		close_out();
	end
endmodule
`default_nettype wire
